// ===== hdl/ltc_pkg.sv
// Constants, state encodings and the state record of the back end
package ltc_pkg;
  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned OUT_HZ    = 16_000;
  localparam int unsigned CHOP_HZ   = 128_000;
  localparam int unsigned CHECK_HZ  = 8_000;
  localparam int unsigned MS_PER_S  = 1_000;
  localparam int unsigned OUT_CYC   = CLK_HZ / OUT_HZ;
  localparam int unsigned CHOP_CYC  = CLK_HZ / CHOP_HZ;
  localparam int unsigned CHECK_CYC = CLK_HZ / CHECK_HZ;
  localparam int unsigned MS_CYC    = CLK_HZ / MS_PER_S;

  localparam logic [11:0] COIL_ON_MS = 12'h010;
  localparam logic [11:0] OFF_MS_F0  = 12'h000;
  localparam logic [11:0] OFF_MS_F1  = 12'h010;
  localparam logic [11:0] OFF_MS_F2  = 12'hFF0;
  localparam logic [1:0]  FREQ_NONE  = 2'h3;

  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_CLAMP  = 6'h08;
  localparam logic [5:0] IDX_COIL   = 6'h09;
  localparam logic [5:0] IDX_LINCTL = 6'h12;
  localparam logic [5:0] IDX_TRIM   = 6'h13;
  localparam logic [5:0] IDX_DIAG   = 6'h14;
  localparam logic [5:0] IDX_STATUS = 6'h15;
  localparam logic [5:0] IDX_TAB0   = 6'h20;

  localparam int LIN_EN_BIT = 12;
  localparam int BIN_BIT    = 13;
  localparam int OINV_BIT   = 14;
  localparam int IINV_BIT   = 15;
  localparam int FREQ_LSB   = 13;
  localparam int GAIN_LSB   = 0;
  localparam int QVO_LSB    = 12;
  localparam int CLH_LSB    = 0;
  localparam int CLL_LSB    = 12;
  localparam int DG_OV      = 0;
  localparam int DG_UV      = 1;
  localparam int DG_BIST    = 2;
  localparam int DG_RANGE   = 3;
  localparam int DG_COIL    = 4;
  localparam int DG_HIZ     = 5;
  localparam int DG_CBDIS   = 6;
  localparam int DG_CCDIS   = 7;
  localparam int DG_REF_LSB = 12;

  localparam logic [23:0] RST_CLAMP  = 24'h000000;
  localparam logic [23:0] RST_COIL   = 24'h000000;
  localparam logic [23:0] RST_LINCTL = 24'h000000;
  localparam logic [23:0] RST_TRIM   = 24'h000000;
  localparam logic [23:0] RST_DIAG   = 24'h80001F;

  localparam int NPTS      = 17;
  localparam int Y_FIRST   = -2048;
  localparam int Y_STEP    = 256;
  localparam int BIN_UNDER = -2304;
  localparam int EXT_LIM   = 2304;
  localparam int S12_MAX   = 2047;
  localparam int S12_MIN   = -2048;
  localparam int U_SHIFT   = 2048;
  localparam int CLAMP_TOP = 4096;
  localparam int DEV_RATIO = 10;
  localparam int GAIN_FRAC = 11;
  localparam logic [4:0] DIV_LAST = 5'h15;

  typedef enum logic [3:0] {
    LS_IDLE  = 4'b0001,
    LS_SETUP = 4'b0010,
    LS_DIV   = 4'b0100,
    LS_TRIM  = 4'b1000
  } ltc_lin_st_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_ON   = 3'b010,
    CS_OFF  = 3'b100
  } ltc_coil_st_t;

  typedef struct packed {
    logic [23:0]         clamp_reg;
    logic [23:0]         coil_reg;
    logic [23:0]         linctl_reg;
    logic [23:0]         trim_reg;
    logic [23:0]         diag_reg;
    logic [16:0][11:0]   tab;
    logic                ap_wr;
    logic [5:0]          ap_idx;
    logic [31:0]         rdata;
    logic [31:0]         out_cnt;
    logic [31:0]         ms_cnt;
    logic [31:0]         chop_cnt;
    logic [31:0]         chk_cnt;
    ltc_lin_st_t         lin_st;
    logic signed [12:0]  samp;
    logic signed [13:0]  y3;
    logic signed [13:0]  ybase;
    logic                qneg;
    logic [4:0]          step;
    logic [21:0]         num;
    logic [11:0]         den;
    logic [12:0]         rem;
    logic [21:0]         quo;
    logic [11:0]         result;
    logic [11:0]         out;
    logic                strobe;
    ltc_coil_st_t        coil_st;
    logic [11:0]         ms_left;
    logic                bist_run;
    logic                chop;
    logic                coil_err;
    logic                derr;
    logic                hiz;
    logic [2:0]          code;
  } ltc_state_t;

  localparam ltc_state_t ST_RESET = '{
    clamp_reg: RST_CLAMP, coil_reg: RST_COIL, linctl_reg: RST_LINCTL,
    trim_reg: RST_TRIM, diag_reg: RST_DIAG, lin_st: LS_IDLE,
    coil_st: CS_IDLE, default: '0};
endpackage : ltc_pkg

// ===== hdl/ltc_lin_trim_clamp.sv
// Linearization, post trim, clamp and coil schedule with AHB-Lite registers
// Operation
// - Bin mode gives -2304 below lowest entry, +2048 above highest.
// - Table applies only when table-enable bit 12 at 0x12 is set.
// - Bit 13 at 0x12 selects binning instead of interpolation.
// - Bit 14 at 0x12 negates the linearization result.
// - Bit 15 at 0x12 negates the sample entering linearization.
// - Trim result is value times one plus gain, plus offset, 12-bit signed.
// - Gain trim is 0x13 bits 11:0, step 2^-11, range -1 to +2047/2048.
// - Offset trim is 0x13 bits 23:12, signed -2048 to +2047.
// - Signed sample becomes unsigned 0..4095 by adding 2048.
// - Above upper gives upper, below lower gives lower, else unchanged.
// - Upper limit is 4096 minus 0x8 bits 11:0.
// - Lower limit is 0x8 bits 23:12 directly.
// - Clamped samples go to the encoder at 16 kHz.
// - Per-source diagnostic enables; error is encoded or high impedance.
// - Coil setting below 3 alternates path at about 128 kHz.
// - Coil signal checked at 8 kHz; over 10% deviation forces error.
// - Coil-diagnostic disable bit suppresses reporting coil path errors.
// - Compensation disable stops compensation, coil checks keep running.
// - Coil on 16 ms; off 0, 16 or 4080 ms per 0x09 bits 14:13.
// - Coil setting 3 runs coil only after a self-test request.
// - Seventeen programmable 12-bit x points, fixed evenly spaced y.
// - Interpolate linearly, extrapolate ends, limit to -2304 and +2304.
// - Bin mode outputs y of highest entry not above the input.
`timescale 1ns/100ps
module ltc_lin_trim_clamp
  import ltc_pkg::*;
#(
  parameter int unsigned OUT_DIV   = OUT_CYC,
  parameter int unsigned CHOP_DIV  = CHOP_CYC,
  parameter int unsigned CHECK_DIV = CHECK_CYC,
  parameter int unsigned MS_DIV    = MS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [12:0] comp_sample,
  input  wire logic        ov_det,
  input  wire logic        uv_det,
  input  wire logic        bist_err,
  input  wire logic        range_err,
  input  wire logic        bist_req,
  input  wire logic [11:0] coil_meas,
  output logic      [11:0] out_sample,
  output logic             out_strobe,
  output logic             diag_err,
  output logic      [2:0]  diag_code,
  output logic             out_hiz,
  output logic             coil_stim_sel,
  output logic             coil_comp_en,
  output logic             coil_active
);

  ltc_state_t s;
  ltc_state_t n;

  function automatic logic signed [13:0] ltc_yv(input logic [4:0] j);
    return 14'(Y_FIRST + Y_STEP * int'(j));
  endfunction : ltc_yv

  function automatic logic signed [13:0] ltc_clip(
    input logic signed [23:0] v);
    if (v > 24'(EXT_LIM)) begin
      return 14'(EXT_LIM);
    end else if (v < -24'(EXT_LIM)) begin
      return -14'(EXT_LIM);
    end
    return v[13:0];
  endfunction : ltc_clip

  function automatic logic [31:0] ltc_rd(input ltc_state_t st,
                                         input logic [5:0] idx);
    logic [5:0] ti;
    ti = idx - IDX_TAB0;
    case (idx)
      IDX_CLAMP:  return {8'h00, st.clamp_reg};
      IDX_COIL:   return {8'h00, st.coil_reg};
      IDX_LINCTL: return {8'h00, st.linctl_reg};
      IDX_TRIM:   return {8'h00, st.trim_reg};
      IDX_DIAG:   return {8'h00, st.diag_reg};
      IDX_STATUS: return {16'h0000, st.coil_err, st.derr | st.hiz,
                          st.coil_st == CS_ON, st.lin_st != LS_IDLE,
                          st.out};
      default: begin
        if (idx >= IDX_TAB0 && ti < 6'(NPTS)) begin
          return {20'h00000, st.tab[ti[4:0]]};
        end
        return 32'h00000000;
      end
    endcase
  endfunction : ltc_rd

  always_comb begin
    logic                take;
    logic [4:0]          k;
    logic [4:0]          seg;
    logic signed [12:0]  xa;
    logic signed [12:0]  xb;
    logic signed [13:0]  dx;
    logic signed [13:0]  diff;
    logic [13:0]         ad;
    logic [12:0]         r;
    logic                qb;
    logic [21:0]         qn;
    logic signed [23:0]  yq;
    logic signed [14:0]  yi;
    logic signed [26:0]  prod;
    logic signed [27:0]  t;
    logic signed [11:0]  ts;
    logic [12:0]         u;
    logic [12:0]         up;
    logic [12:0]         lo;
    logic [1:0]          f;
    logic [11:0]         offt;
    logic [11:0]         dev;
    logic [11:0]         cref;
    logic                ms_tick;
    logic                coil_rep;
    logic [4:0]          src;
    logic [5:0]          wi;
    n    = s;
    take = hsel & htrans[1] & hready;
    k    = 5'h00;
    seg  = 5'h00;
    xa   = '0;
    xb   = '0;
    dx   = '0;
    diff = '0;
    ad   = '0;
    r    = {s.rem[11:0], s.num[21]};
    qb   = 1'b0;
    qn   = '0;
    yq   = '0;
    yi   = '0;
    prod = '0;
    t    = '0;
    ts   = '0;
    u    = '0;
    up   = '0;
    lo   = '0;
    f    = s.coil_reg[FREQ_LSB +: 2];
    offt = OFF_MS_F2;
    dev  = '0;
    cref = s.diag_reg[DG_REF_LSB +: 12];
    wi   = s.ap_idx - IDX_TAB0;
    ms_tick = s.ms_cnt >= MS_DIV - 1;
    coil_rep = s.coil_err & ~s.diag_reg[DG_CBDIS];
    src = {coil_rep & s.diag_reg[DG_COIL],
           range_err & s.diag_reg[DG_RANGE],
           bist_err & s.diag_reg[DG_BIST],
           uv_det & s.diag_reg[DG_UV],
           ov_det & s.diag_reg[DG_OV]};

    // Register write lands in the data phase
    if (s.ap_wr) begin
      case (s.ap_idx)
        IDX_CLAMP:  n.clamp_reg  = hwdata[23:0];
        IDX_COIL:   n.coil_reg   = hwdata[23:0];
        IDX_LINCTL: n.linctl_reg = hwdata[23:0];
        IDX_TRIM:   n.trim_reg   = hwdata[23:0];
        IDX_DIAG:   n.diag_reg   = hwdata[23:0];
        default: begin
          if (s.ap_idx >= IDX_TAB0 && wi < 6'(NPTS)) begin
            n.tab[wi[4:0]] = hwdata[11:0];
          end
        end
      endcase
    end
    n.ap_wr  = take & hwrite;
    n.ap_idx = haddr[7:2];
    // Read sees the write that finishes in the same cycle
    if (take & ~hwrite) begin
      n.rdata = ltc_rd(n, haddr[7:2]);
    end

    // Output period strobe
    n.strobe = 1'b0;
    if (s.out_cnt >= OUT_DIV - 1) begin
      n.out_cnt = '0;
      n.strobe  = 1'b1;
      n.out     = s.result;
      n.lin_st  = LS_SETUP;
      if (s.linctl_reg[IINV_BIT]) begin
        n.samp = ($signed(comp_sample) == -13'sd4096) ? 13'sd4095
                 : -$signed(comp_sample);
      end else begin
        n.samp = $signed(comp_sample);
      end
    end else begin
      n.out_cnt = s.out_cnt + 32'h00000001;
    end

    for (int j = 0; j < NPTS; j++) begin
      if ($signed(s.tab[j]) <= s.samp) begin
        k = k + 5'h01;
      end
    end
    if (k == 5'h00) begin
      seg = 5'h00;
    end else if (k >= 5'h10) begin
      seg = 5'h0F;
    end else begin
      seg = k - 5'h01;
    end
    xa   = 13'($signed(s.tab[seg]));
    xb   = 13'($signed(s.tab[seg + 5'h01]));
    dx   = 14'(xb) - 14'(xa);
    diff = 14'(s.samp) - 14'(xa);
    ad   = diff < 0 ? 14'(-diff) : 14'(diff);

    if (r >= {1'b0, s.den}) begin
      r  = r - {1'b0, s.den};
      qb = 1'b1;
    end
    qn = {s.quo[20:0], qb};

    case (s.lin_st)
      LS_IDLE: begin
      end
      LS_SETUP: begin
        n.lin_st = LS_TRIM;
        if (!s.linctl_reg[LIN_EN_BIT]) begin
          n.y3 = 14'(s.samp);
        end else if (s.linctl_reg[BIN_BIT]) begin
          n.y3 = (k == 5'h00) ? 14'(BIN_UNDER)
                 : ltc_yv(k - 5'h01);
        end else if (dx <= 0) begin
          // Equal or descending neighbours: take the upper y, or -2304/+2304 below/above the whole table, no division
          n.y3 = (k == 5'h00) ? -14'(EXT_LIM)
                 : (k == 5'(NPTS)) ? 14'(EXT_LIM)
                 : ltc_yv(seg + 5'h01);
        end else begin
          n.lin_st = LS_DIV;
          n.ybase  = ltc_yv(seg);
          n.qneg   = diff < 0;
          n.num    = {ad, 8'h00};
          n.den    = dx[11:0];
          n.rem    = '0;
          n.quo    = '0;
          n.step   = '0;
        end
      end
      LS_DIV: begin
        n.rem  = r;
        n.num  = {s.num[20:0], 1'b0};
        n.quo  = qn;
        n.step = s.step + 5'h01;
        if (s.step == DIV_LAST) begin
          yq = s.qneg ? 24'(s.ybase) - $signed({2'b00, qn})
               : 24'(s.ybase) + $signed({2'b00, qn});
          n.y3     = ltc_clip(yq);
          n.lin_st = LS_TRIM;
        end
      end
      LS_TRIM: begin
        yi = s.linctl_reg[OINV_BIT] ? -15'(s.y3) : 15'(s.y3);
        prod = yi * $signed(s.trim_reg[GAIN_LSB +: 12]);
        t = 28'(yi) + 28'(prod >>> GAIN_FRAC)
            + 28'($signed(s.trim_reg[QVO_LSB +: 12]));
        if (t > 28'(S12_MAX)) begin
          ts = 12'(S12_MAX);
        end else if (t < 28'(S12_MIN)) begin
          ts = 12'(S12_MIN);
        end else begin
          ts = t[11:0];
        end
        u  = 13'(14'(ts) + 14'(U_SHIFT));
        up = 13'(CLAMP_TOP) - {1'b0, s.clamp_reg[CLH_LSB +: 12]};
        lo = {1'b0, s.clamp_reg[CLL_LSB +: 12]};
        if (u > up) begin
          n.result = up[11:0];
        end else if (u < lo) begin
          n.result = lo[11:0];
        end else begin
          n.result = u[11:0];
        end
        n.lin_st = LS_IDLE;
      end
      default: n.lin_st = LS_IDLE;
    endcase

    // Millisecond base for the coil schedule
    n.ms_cnt = ms_tick ? '0 : s.ms_cnt + 32'h00000001;
    case (f)
      2'h0:    offt = OFF_MS_F0;
      2'h1:    offt = OFF_MS_F1;
      default: offt = OFF_MS_F2;
    endcase
    case (s.coil_st)
      CS_IDLE: begin
        if (f != FREQ_NONE) begin
          n.coil_st = CS_ON;
          n.ms_left = COIL_ON_MS;
        end else if (bist_req) begin
          n.coil_st  = CS_ON;
          n.ms_left  = COIL_ON_MS;
          n.bist_run = 1'b1;
        end
      end
      CS_ON: begin
        if (ms_tick) begin
          if (s.ms_left <= 12'h001) begin
            if (s.bist_run || f == FREQ_NONE) begin
              n.coil_st  = CS_IDLE;
              n.bist_run = 1'b0;
            end else if (offt == 12'h000) begin
              n.ms_left = COIL_ON_MS;
            end else begin
              n.coil_st = CS_OFF;
              n.ms_left = offt;
            end
          end else begin
            n.ms_left = s.ms_left - 12'h001;
          end
        end
      end
      CS_OFF: begin
        if (f == FREQ_NONE) begin
          n.coil_st = CS_IDLE;
        end else if (ms_tick) begin
          if (s.ms_left <= 12'h001) begin
            n.coil_st = CS_ON;
            n.ms_left = COIL_ON_MS;
          end else begin
            n.ms_left = s.ms_left - 12'h001;
          end
        end
      end
      default: n.coil_st = CS_IDLE;
    endcase

    // Path time-share and monitor run only while the coil is on
    n.chop_cnt = (s.chop_cnt >= CHOP_DIV - 1) ? '0
                 : s.chop_cnt + 32'h00000001;
    n.chk_cnt  = (s.chk_cnt >= CHECK_DIV - 1) ? '0
                 : s.chk_cnt + 32'h00000001;
    if (s.coil_st != CS_ON) begin
      n.chop = 1'b0;
    end else if (s.chop_cnt >= CHOP_DIV - 1) begin
      n.chop = ~s.chop;
    end
    if (s.coil_st == CS_ON && s.chk_cnt >= CHECK_DIV - 1) begin
      dev = (coil_meas > cref) ? coil_meas - cref : cref - coil_meas;
      n.coil_err = 16'(dev) * 16'(DEV_RATIO) > 16'(cref);
    end

    n.derr = (|src) & ~s.diag_reg[DG_HIZ];
    n.hiz  = (|src) & s.diag_reg[DG_HIZ];
    if (src[0]) begin
      n.code = 3'h1;
    end else if (src[1]) begin
      n.code = 3'h2;
    end else if (src[2]) begin
      n.code = 3'h3;
    end else if (src[3]) begin
      n.code = 3'h4;
    end else if (src[4]) begin
      n.code = 3'h5;
    end else begin
      n.code = 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= ST_RESET;
    end else begin
      s <= n;
    end
  end

  // Zero wait states, never an error response
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s.rdata;
  assign out_sample    = s.out;
  assign out_strobe    = s.strobe;
  assign diag_err      = s.derr;
  assign diag_code     = s.code;
  assign out_hiz       = s.hiz;
  assign coil_stim_sel = s.chop;
  assign coil_active   = s.coil_st == CS_ON;
  assign coil_comp_en  = coil_active & ~s.diag_reg[DG_CCDIS];
endmodule : ltc_lin_trim_clamp

// ===== verif/ltc_chk_assertions.sv
// Port-level assertions for the back end, with their bind
`timescale 1ns/100ps
module ltc_chk
  import ltc_pkg::*;
#(
  parameter int unsigned OUT_DIV = OUT_CYC
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        ov_det,
  input wire logic        uv_det,
  input wire logic        bist_err,
  input wire logic        range_err,
  input wire logic        bist_req,
  input wire logic [11:0] out_sample,
  input wire logic        out_strobe,
  input wire logic        diag_err,
  input wire logic [2:0]  diag_code,
  input wire logic        out_hiz,
  input wire logic        coil_comp_en,
  input wire logic        coil_active
);
  logic [23:0] dg_q;
  logic [1:0]  cf_q;
  logic        wr_q;
  logic [5:0]  ix_q;
  logic [31:0] st_q;
  logic        seen_q;
  logic        en_err;
  // Shadow only the diag word and the coil frequency bits; no other register word is modelled here
  assign en_err = (ov_det & dg_q[DG_OV]) | (uv_det & dg_q[DG_UV])
                | (bist_err & dg_q[DG_BIST]) | (range_err & dg_q[DG_RANGE]);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dg_q   <= RST_DIAG;
      cf_q   <= 2'h0;
      wr_q   <= 1'b0;
      ix_q   <= 6'h00;
      st_q   <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      wr_q   <= hsel & htrans[1] & hready & hwrite;
      ix_q   <= haddr[7:2];
      if (wr_q && ix_q == IDX_DIAG)
        dg_q <= hwdata[23:0];
      if (wr_q && ix_q == IDX_COIL)
        cf_q <= hwdata[FREQ_LSB+1:FREQ_LSB];
      st_q   <= out_strobe ? 32'h0 : st_q + 32'h1;
      seen_q <= seen_q | out_strobe;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_strobe_pulse: assert property (out_strobe |=> !out_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_period: assert property (seen_q |->
    out_strobe == (st_q == OUT_DIV - 1))
    else $error("strobe period wrong");
  a_out_hold: assert property (!out_strobe |-> $stable(out_sample))
    else $error("sample moved between strobes");
  a_err_code: assert property (ov_det && dg_q[DG_OV] && !dg_q[DG_HIZ]
    |=> diag_err && diag_code == 3'h1)
    else $error("overvoltage not encoded");
  a_hiz_mode: assert property (en_err && dg_q[DG_HIZ]
    |=> out_hiz && !diag_err)
    else $error("high impedance mode ignored");
  a_quiet_out: assert property (!en_err && (!dg_q[DG_COIL] || dg_q[DG_CBDIS])
    |=> !diag_err && !out_hiz)
    else $error("error without enabled source");
  a_comp_gate: assert property (coil_comp_en ==
    (coil_active && !dg_q[DG_CCDIS]))
    else $error("compensation enable wrong");
  a_freq_idle: assert property (cf_q == FREQ_NONE && !coil_active
    && !bist_req |=> !coil_active)
    else $error("coil started without request");
  c_frame: cover property (out_strobe);
  c_coil_err: cover property (diag_err && diag_code == 3'h5);
  c_hiz: cover property (out_hiz);
endmodule : ltc_chk

bind ltc_lin_trim_clamp ltc_chk #(.OUT_DIV(OUT_DIV)) u_chk (
  .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .ov_det(ov_det),
  .uv_det(uv_det), .bist_err(bist_err), .range_err(range_err),
  .bist_req(bist_req), .out_sample(out_sample), .out_strobe(out_strobe),
  .diag_err(diag_err), .diag_code(diag_code), .out_hiz(out_hiz),
  .coil_comp_en(coil_comp_en), .coil_active(coil_active)
);

// ===== verif/ltc_enc_model.sv
// Output encoder stand-in that takes each strobed sample
`timescale 1ns/100ps
module ltc_enc_model (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [11:0] out_sample,
  input  wire logic        out_strobe,
  output logic      [11:0] frame_q,
  output logic      [31:0] nframes_q
);
  // Samples only on the strobe, so a late output change is missed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_q   <= 12'h000;
      nframes_q <= 32'h0;
    end else if (out_strobe) begin
      frame_q   <= out_sample;
      nframes_q <= nframes_q + 32'h1;
    end
  end
endmodule : ltc_enc_model

// ===== verif/tb_top.sv
// Self-checking bench for the linearize, trim and clamp back end
`timescale 1ns/100ps
module tb_top;
  import ltc_pkg::*;
  localparam int MD = 20;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [12:0] comp_sample = 13'h0000;
  logic [3:0]  dg = 4'h0;
  logic        bist_req = 1'b0;
  logic [11:0] coil_meas = 12'h800;
  logic [31:0] hrdata, nfr;
  logic [11:0] out_sample, frame;
  logic [2:0]  diag_code;
  logic        hreadyout, hresp, hready, out_strobe, diag_err, out_hiz;
  logic        coil_stim_sel, coil_comp_en, coil_active;
  int          miscompares = 0;
  int          n_tests = 0;
  int          seed = 32'h0A91;
  assign hready = hreadyout;
  always #2 mclk = ~mclk;
  ltc_lin_trim_clamp #(.OUT_DIV(64), .CHOP_DIV(8), .CHECK_DIV(16),
    .MS_DIV(MD)) u_dut (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .comp_sample(comp_sample), .ov_det(dg[0]), .uv_det(dg[1]),
    .bist_err(dg[2]), .range_err(dg[3]), .bist_req(bist_req),
    .coil_meas(coil_meas), .out_sample(out_sample), .out_strobe(out_strobe),
    .diag_err(diag_err), .diag_code(diag_code), .out_hiz(out_hiz),
    .coil_stim_sel(coil_stim_sel), .coil_comp_en(coil_comp_en),
    .coil_active(coil_active));
  ltc_enc_model u_enc (.mclk(mclk), .nrst(nrst), .out_sample(out_sample),
    .out_strobe(out_strobe), .frame_q(frame), .nframes_q(nfr));
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] seen, ex);
    n_tests++;
    if (seen !== ex) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check
  // Land after the edge so registered outputs are settled
  task automatic step;
    @(posedge mclk);
    #1;
  endtask : step
  task automatic ahb(input logic wr, input logic [5:0] ix,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, ix, 2'h0};
    do step; while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do step; while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", hresp, 1'b0);
  endtask : ahb
  task automatic wreg(input logic [5:0] ix, input logic [31:0] wd);
    logic [31:0] rd;
    ahb(1'b1, ix, wd, rd);
  endtask : wreg
  task automatic rchk(input logic [5:0] ix, input logic [31:0] ex);
    logic [31:0] rd;
    ahb(1'b0, ix, 32'h0, rd);
    check("hrdata", rd, ex);
  endtask : rchk
  task automatic strobes(input int n);
    logic [31:0] tgt;
    int k;
    tgt = nfr + n;
    k = 0;
    while (nfr !== tgt && k < 1000) begin
      step;
      k++;
    end
    check("frames", nfr, tgt);
  endtask : strobes
  task automatic lvl(input logic lv, output int n);
    n = 0;
    while (coil_active === lv && n < 2000) begin
      step;
      n++;
    end
  endtask : lvl
  function automatic int xpt(input int j);
    return -1024 + 128 * j;
  endfunction : xpt
  function automatic logic [11:0] expect_out(input logic signed [12:0] s,
                                             input logic [23:0] lc, tr, cl);
    int y;
    int u;
    int up;
    y = s;
    if (lc[IINV_BIT])
      y = (y == -4096) ? 4095 : -y;
    if (lc[LIN_EN_BIT] && lc[BIN_BIT]) begin
      u = BIN_UNDER;
      for (int j = 0; j < NPTS; j++)
        if (xpt(j) <= y) u = Y_FIRST + Y_STEP * j;
      y = u;
    end else if (lc[LIN_EN_BIT]) begin
      // Even spacing of 128 gives every segment a slope of two
      y = 2 * y;
      if (y > EXT_LIM) y = EXT_LIM;
      if (y < -EXT_LIM) y = -EXT_LIM;
    end
    if (lc[OINV_BIT])
      y = -y;
    y = y + ((y * int'($signed(tr[11:0]))) >>> GAIN_FRAC);
    y = y + int'($signed(tr[23:12]));
    if (y > S12_MAX) y = S12_MAX;
    if (y < S12_MIN) y = S12_MIN;
    u = y + U_SHIFT;
    up = CLAMP_TOP - int'(cl[11:0]);
    if (u > up) u = up;
    else if (u < int'(cl[23:12])) u = int'(cl[23:12]);
    return u[11:0];
  endfunction : expect_out
  task automatic run(input logic [12:0] s, input logic [23:0] lc, tr, cl);
    wreg(IDX_LINCTL, {8'h00, lc});
    wreg(IDX_TRIM, {8'h00, tr});
    wreg(IDX_CLAMP, {8'h00, cl});
    comp_sample <= s;
    strobes(3); // Earlier strobe may hold the old sample
    check("sample", frame, expect_out(s, lc, tr, cl));
  endtask : run
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  initial begin
    logic [31:0] r;
    logic [31:0] c;
    int i;
    int n;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    step;
    rchk(IDX_CLAMP, {8'h00, RST_CLAMP});
    rchk(IDX_COIL, {8'h00, RST_COIL});
    rchk(IDX_LINCTL, {8'h00, RST_LINCTL});
    rchk(IDX_DIAG, {8'h00, RST_DIAG});
    rchk(6'h3F, 32'h0);
    wreg(IDX_TRIM, 32'hFFFFFFFF);
    rchk(IDX_TRIM, 32'h00FFFFFF);
    for (i = 0; i < NPTS; i++)
      wreg(6'(IDX_TAB0 + i), {20'h0, 12'(xpt(i))});
    rchk(IDX_TAB0 + 6'h10, 32'h400);
    run(13'h1000, 24'h008000, 24'h0, 24'h0);
    run(13'h05DC, 24'h002000, 24'h0, 24'h0);
    run(13'h05DC, 24'h003000, 24'hFFF000, 24'h0);
    run(13'h1A24, 24'h003000, 24'h101000, 24'h0);
    run(13'h1E80, 24'h003000, 24'h0, 24'h0);
    run(13'h1E7F, 24'h003000, 24'h0, 24'h0);
    run(13'h04B0, 24'h001000, 24'hED4000, 24'h0);
    run(13'h0064, 24'h005000, 24'h0, 24'h0);
    run(13'h07D0, 24'h0, 24'h0, 24'h000064);
    run(13'h1830, 24'h0, 24'h0, 24'h1F4000);
    run(13'h0400, 24'h0, 24'h7FF000, 24'h0);
    run(13'h0400, 24'h0, 24'h000800, 24'h0);
    for (i = 0; i < 36; i++) begin
      r = $random(seed);
      c = $random(seed);
      c = {8'h00, 1'b0, c[22:12], 1'b0, c[10:0]};
      run(r[12:0], {8'h00, r[31:28], 12'h000}, 24'($random(seed)), c[23:0]);
    end
    for (i = 0; i < 5; i++) begin
      dg <= (i == 4) ? 4'hF : 4'h1 << i;
      repeat (3) step;
      check("code", diag_code, (i == 4) ? 1 : i + 1);
      check("err", diag_err, 1'b1);
    end
    wreg(IDX_DIAG, 32'h0080001E);
    dg <= 4'h1;
    repeat (3) step;
    check("err", diag_err, 1'b0);
    wreg(IDX_DIAG, 32'h0080003F);
    dg <= 4'h2;
    repeat (3) step;
    check("hiz", {out_hiz, diag_err}, 2'h2);
    dg <= 4'h0;
    wreg(IDX_DIAG, {8'h00, RST_DIAG});
    coil_meas <= 12'h8CC;
    repeat (40) step;
    check("err", diag_err, 1'b0);
    coil_meas <= 12'h8CD;
    repeat (40) step;
    check("code", {diag_err, diag_code}, 4'hD);
    wreg(IDX_DIAG, 32'h0080005F);
    repeat (3) step;
    check("err", diag_err, 1'b0);
    wreg(IDX_DIAG, 32'h0080009F);
    repeat (40) step;
    check("comp", {diag_err, coil_active, coil_comp_en}, 3'h6);
    n = 0;
    for (i = 0; i < 160; i++) begin
      r[0] = coil_stim_sel;
      step;
      n += (coil_stim_sel !== r[0]);
    end
    check("chop", n >= 19 && n <= 21, 1'b1);
    coil_meas <= 12'h800;
    wreg(IDX_DIAG, {8'h00, RST_DIAG});
    wreg(IDX_COIL, 32'h00002000);
    lvl(1'b1, n);
    lvl(1'b0, n);
    check("off", n, 16 * MD);
    lvl(1'b1, n);
    check("on", n, 16 * MD);
    wreg(IDX_COIL, 32'h00006000);
    lvl(1'b1, n);
    repeat (400) step;
    check("idle", coil_active, 1'b0);
    bist_req <= 1'b1;
    step;
    bist_req <= 1'b0;
    step;
    lvl(1'b1, n);
    check("bist", n >= 15 * MD - 1 && n <= 16 * MD, 1'b1);
    repeat (400) step;
    check("idle", coil_active, 1'b0);
    close_out;
  end
endmodule : tb_top
